// ---- hdl/flash_query_info_rom_regs.svh ----
// Purpose: offsets, values and field positions of the query information store
// Assumes: byte-wide query locations, offsets in query address units
// Notes:   definitions only
`ifndef FLASH_QUERY_INFO_ROM_REGS_SVH
`define FLASH_QUERY_INFO_ROM_REGS_SVH

`define QRY_ADDR_W              8
`define QRY_EXT_PTR_OFS         8'h15
`define QRY_EXT_PTR_VAL         16'h0031
`define QRY_SYS_BASE            8'h1b
`define QRY_LAST_OFS            8'h3a
`define QRY_LOGIC_MIN_OFS       8'h1b
`define QRY_LOGIC_MAX_OFS       8'h1c
`define QRY_PROG_MIN_OFS        8'h1d
`define QRY_PROG_MAX_OFS        8'h1e
`define QRY_TYP_WORD_OFS        8'h1f
`define QRY_TYP_BUF_OFS         8'h20
`define QRY_TYP_BLK_OFS         8'h21
`define QRY_TYP_CHIP_OFS        8'h22
`define QRY_MAX_WORD_OFS        8'h23
`define QRY_MAX_BUF_OFS         8'h24
`define QRY_MAX_BLK_OFS         8'h25
`define QRY_MAX_CHIP_OFS        8'h26
`define QRY_SIZE_OFS            8'h27
`define QRY_IFACE_OFS           8'h28
`define QRY_WBUF_OFS            8'h2a
`define QRY_REGIONS_OFS         8'h2c
`define QRY_REGION_OFS          8'h2d
`define QRY_SIG_OFS             8'h31
`define QRY_MAJOR_OFS           8'h34
`define QRY_MINOR_OFS           8'h35
`define QRY_FEAT_OFS            8'h36
`define QRY_SUSP_OFS            8'h3a

`define QRY_LOGIC_MIN_VAL       8'h27
`define QRY_LOGIC_MAX_VAL       8'h36
`define QRY_PROG_MIN_VAL        8'h00
`define QRY_PROG_MAX_VAL        8'h00
`define QRY_TYP_WORD_VAL        8'h08
`define QRY_TYP_BUF_VAL         8'h09
`define QRY_TYP_BLK_VAL         8'h0a
`define QRY_TYP_CHIP_VAL        8'h00
`define QRY_MAX_WORD_VAL        8'h01
`define QRY_MAX_BUF_VAL         8'h01
`define QRY_MAX_BLK_VAL         8'h02
`define QRY_MAX_CHIP_VAL        8'h00
`define QRY_SIZE_64M            8'h17
`define QRY_SIZE_128M           8'h18
`define QRY_SIZE_256M           8'h19
`define QRY_IFACE_VAL           16'h0001
`define QRY_WBUF_VAL            16'h0006
`define QRY_REGIONS_VAL         8'h01
`define QRY_BLKS_64M            16'h003f
`define QRY_BLKS_128M           16'h007f
`define QRY_BLKS_256M           16'h00ff
`define QRY_BLK_SIZE_VAL        16'h0200
`define QRY_SIG_VAL             24'h49_5250
`define QRY_MAJOR_VAL           8'h31
`define QRY_MINOR_VAL           8'h31
`define QRY_FEAT_VAL            32'h0000_01e6
`define QRY_SUSP_VAL            8'h01
`define QRY_READ_CMD            8'hff
`define QRY_QUERY_CMD           8'h98

`endif

// ---- hdl/flash_query_info_rom_pkg.sv ----
// Purpose: types of the query information store
// Assumes: constants come from the register header
// Notes:   read request and answer carried as structs
package flash_query_info_rom_pkg;

    typedef enum logic [1:0] {
        DENS_64M,
        DENS_128M,
        DENS_256M
    } density_t;

    typedef enum logic {
        MODE_ARRAY,
        MODE_QUERY
    } read_mode_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] offset;
    } query_req_t;

    typedef struct packed {
        logic        valid;
        logic        hit;
        logic [15:0] data;
    } query_rsp_t;

endpackage : flash_query_info_rom_pkg

// ---- hdl/flash_query_info_rom.sv ----
// Purpose: read-only query information bytes from 1Bh to 3Ah of a NOR flash
// Assumes: command writes and reads synchronous to i_clk_sys; one read a cycle
// Notes:   answer one cycle after the read; array data passes through in array mode
//
// Functional notes
// - query command switches reads to query bytes instead of array data
// - pointer at 15h holds 0031h, base of the vendor extended table
// - system interface group starts at 1Bh, one byte per location
// - logic supply min and max voltage read 27 and 36
// - programming supply min and max voltage both read 00
// - typical word program time-out exponent reads 08
// - typical buffer write time-out exponent reads 09
// - typical block erase time-out exponent reads 0A
// - typical and maximum whole chip erase time-outs read zero
// - max word program and buffer write multipliers read 01
// - max block erase multiplier reads 02
// - device size exponent reads 17h, 18h or 19h by density
// - interface code at 28h reads 01 then 00, sixteen-bit bus
// - write buffer size field reads exponent 06 then 00
// - erase region count reads 01
// - region descriptor: block count minus one, then size 0200h
// - extended table starts with signature bytes 50, 52, 49
// - major and minor version bytes each read 31
// - optional feature field reads E6, 01, 00, 00
// - after suspend function byte reads 01
`include "flash_query_info_rom_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module flash_query_info_rom
    import flash_query_info_rom_pkg::*;
#(
    parameter density_t DENSITY = DENS_128M
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_reset,
    input  wire logic        i_clk_en,
    input  wire logic        i_cmd_we,
    input  wire logic [7:0]  i_cmd_data,
    input  wire query_req_t  i_req,
    input  wire logic [15:0] i_array_data,
    output var  query_rsp_t  o_rsp,
    output logic             o_query_mode
);

    // refuse a density the tables cannot describe, at elaboration
    if (DENSITY != DENS_64M && DENSITY != DENS_128M && DENSITY != DENS_256M) begin : g_bad
        $error("unsupported density");
    end

    // multi-byte field values as constants, so that single bytes can be selected
    localparam logic [15:0] EXT_PTR  = `QRY_EXT_PTR_VAL;
    localparam logic [15:0] IFACE    = `QRY_IFACE_VAL;
    localparam logic [15:0] WBUF     = `QRY_WBUF_VAL;
    localparam logic [15:0] BLK_SIZE = `QRY_BLK_SIZE_VAL;
    localparam logic [23:0] SIG      = `QRY_SIG_VAL;
    localparam logic [31:0] FEAT     = `QRY_FEAT_VAL;

    read_mode_t mode_q;
    query_rsp_t rsp_q;
    query_rsp_t rsp_d;

    // byte at one query location, zero outside the stored range
    function automatic logic [8:0] query_byte(input logic [7:0] ofs, input density_t dens);
        logic [7:0]  size_exp;
        logic [15:0] blks;
        logic [8:0]  r;
        size_exp = (dens == DENS_64M) ? `QRY_SIZE_64M :
                   (dens == DENS_128M) ? `QRY_SIZE_128M : `QRY_SIZE_256M;
        blks     = (dens == DENS_64M) ? `QRY_BLKS_64M :
                   (dens == DENS_128M) ? `QRY_BLKS_128M : `QRY_BLKS_256M;
        r        = 9'h000;
        case (ofs)
            `QRY_EXT_PTR_OFS:       r = {1'b1, EXT_PTR[7:0]};
            `QRY_EXT_PTR_OFS + 8'h01: r = {1'b1, EXT_PTR[15:8]};
            `QRY_LOGIC_MIN_OFS:     r = {1'b1, `QRY_LOGIC_MIN_VAL};
            `QRY_LOGIC_MAX_OFS:     r = {1'b1, `QRY_LOGIC_MAX_VAL};
            `QRY_PROG_MIN_OFS:      r = {1'b1, `QRY_PROG_MIN_VAL};
            `QRY_PROG_MAX_OFS:      r = {1'b1, `QRY_PROG_MAX_VAL};
            `QRY_TYP_WORD_OFS:      r = {1'b1, `QRY_TYP_WORD_VAL};
            `QRY_TYP_BUF_OFS:       r = {1'b1, `QRY_TYP_BUF_VAL};
            `QRY_TYP_BLK_OFS:       r = {1'b1, `QRY_TYP_BLK_VAL};
            `QRY_TYP_CHIP_OFS:      r = {1'b1, `QRY_TYP_CHIP_VAL};
            `QRY_MAX_WORD_OFS:      r = {1'b1, `QRY_MAX_WORD_VAL};
            `QRY_MAX_BUF_OFS:       r = {1'b1, `QRY_MAX_BUF_VAL};
            `QRY_MAX_BLK_OFS:       r = {1'b1, `QRY_MAX_BLK_VAL};
            `QRY_MAX_CHIP_OFS:      r = {1'b1, `QRY_MAX_CHIP_VAL};
            `QRY_SIZE_OFS:          r = {1'b1, size_exp};
            `QRY_IFACE_OFS:         r = {1'b1, IFACE[7:0]};
            `QRY_IFACE_OFS + 8'h01: r = {1'b1, IFACE[15:8]};
            `QRY_WBUF_OFS:          r = {1'b1, WBUF[7:0]};
            `QRY_WBUF_OFS + 8'h01:  r = {1'b1, WBUF[15:8]};
            `QRY_REGIONS_OFS:       r = {1'b1, `QRY_REGIONS_VAL};
            `QRY_REGION_OFS:        r = {1'b1, blks[7:0]};
            `QRY_REGION_OFS + 8'h01: r = {1'b1, blks[15:8]};
            `QRY_REGION_OFS + 8'h02: r = {1'b1, BLK_SIZE[7:0]};
            `QRY_REGION_OFS + 8'h03: r = {1'b1, BLK_SIZE[15:8]};
            `QRY_SIG_OFS:           r = {1'b1, SIG[7:0]};
            `QRY_SIG_OFS + 8'h01:   r = {1'b1, SIG[15:8]};
            `QRY_SIG_OFS + 8'h02:   r = {1'b1, SIG[23:16]};
            `QRY_MAJOR_OFS:         r = {1'b1, `QRY_MAJOR_VAL};
            `QRY_MINOR_OFS:         r = {1'b1, `QRY_MINOR_VAL};
            `QRY_FEAT_OFS:          r = {1'b1, FEAT[7:0]};
            `QRY_FEAT_OFS + 8'h01:  r = {1'b1, FEAT[15:8]};
            `QRY_FEAT_OFS + 8'h02:  r = {1'b1, FEAT[23:16]};
            `QRY_FEAT_OFS + 8'h03:  r = {1'b1, FEAT[31:24]};
            `QRY_SUSP_OFS:          r = {1'b1, `QRY_SUSP_VAL};
            default:                r = 9'h000;
        endcase
        return r;
    endfunction : query_byte

    // read mode follows the read-array and query commands
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            mode_q <= MODE_ARRAY;
        end else if (i_clk_en && i_cmd_we) begin
            if (i_cmd_data == `QRY_QUERY_CMD) begin
                mode_q <= MODE_QUERY;
            end else if (i_cmd_data == `QRY_READ_CMD) begin
                mode_q <= MODE_ARRAY;
            end
        end
    end

    // read path selection
    always_comb begin
        logic [8:0] qb;
        qb    = query_byte(i_req.offset, DENSITY);
        rsp_d = '0;
        rsp_d.valid = i_req.valid;
        case (mode_q)
            MODE_QUERY: begin
                rsp_d.hit  = i_req.valid & qb[8];
                rsp_d.data = {8'h00, qb[7:0]};
            end
            MODE_ARRAY: begin
                rsp_d.data = i_array_data;
            end
            default: begin
                rsp_d.data = 16'h0000;
            end
        endcase
    end

    // registered answer
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            rsp_q <= '0;
        end else if (i_clk_en) begin
            rsp_q <= rsp_d;
        end
    end

    assign o_rsp        = rsp_q;
    assign o_query_mode = (mode_q == MODE_QUERY);

    // assertions
    AST_QUERY_ENTER: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_clk_en && i_cmd_we && i_cmd_data == `QRY_QUERY_CMD) |=> o_query_mode)
        else $error("query command did not enter query mode");
    AST_UPPER_ZERO: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        ($past(i_clk_en) && $past(o_query_mode) && o_rsp.valid) |-> o_rsp.data[15:8] == 8'h00)
        else $error("upper query lines not zero");
    AST_POINTER: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_clk_en && o_query_mode && i_req.valid && i_req.offset == 8'h15)
        |=> (o_rsp.hit && o_rsp.data == 16'h0031))
        else $error("extended pointer wrong");
    AST_VOLT: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_clk_en && o_query_mode && i_req.valid && i_req.offset == 8'h1c)
        |=> o_rsp.data == 16'h0036)
        else $error("logic supply max wrong");
    AST_VPP: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_clk_en && o_query_mode && i_req.valid && i_req.offset == 8'h1d)
        |=> (o_rsp.hit && o_rsp.data == 16'h0000))
        else $error("programming supply min wrong");
    AST_BLK_ERASE: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_clk_en && o_query_mode && i_req.valid && i_req.offset == 8'h21)
        |=> o_rsp.data == 16'h000a)
        else $error("block erase time-out wrong");
    AST_MAX_BLK: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_clk_en && o_query_mode && i_req.valid && i_req.offset == 8'h25)
        |=> o_rsp.data == 16'h0002)
        else $error("max block erase multiplier wrong");
    AST_FEAT: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_clk_en && o_query_mode && i_req.valid && i_req.offset == 8'h36)
        |=> o_rsp.data == 16'h00e6)
        else $error("feature low byte wrong");
    AST_SIG: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_clk_en && o_query_mode && i_req.valid && i_req.offset == 8'h31)
        |=> o_rsp.data == 16'h0050)
        else $error("signature first byte wrong");
    AST_SUSP: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_clk_en && o_query_mode && i_req.valid && i_req.offset == 8'h3a)
        |=> o_rsp.data == 16'h0001)
        else $error("after suspend byte wrong");
    AST_ARRAY_PASS: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_clk_en && !o_query_mode && i_req.valid) |=> o_rsp.data == $past(i_array_data))
        else $error("array data not passed in array mode");

    // expected bytes of the density-dependent locations
    localparam logic [7:0] CHK_SIZE = (DENSITY == DENS_64M)  ? 8'h17 :
                                      (DENSITY == DENS_128M) ? 8'h18 : 8'h19;
    localparam logic [7:0] CHK_BLKS = (DENSITY == DENS_64M)  ? 8'h3f :
                                      (DENSITY == DENS_128M) ? 8'h7f : 8'hff;

    // one assertion per stored field that the ones above leave open, except 1Eh, 24h and 35h, which none checks
    AST_SYS_BASE: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_clk_en && o_query_mode && i_req.valid && i_req.offset == 8'h1b)
        |=> (o_rsp.hit && o_rsp.data == 16'h0027))
        else $error("first system interface byte wrong");
    AST_TYP_WORD: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_clk_en && o_query_mode && i_req.valid && i_req.offset == 8'h1f)
        |=> (o_rsp.hit && o_rsp.data == 16'h0008))
        else $error("typical word program time-out wrong");
    AST_TYP_BUF: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_clk_en && o_query_mode && i_req.valid && i_req.offset == 8'h20)
        |=> (o_rsp.hit && o_rsp.data == 16'h0009))
        else $error("typical buffer write time-out wrong");
    AST_TYP_CHIP: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_clk_en && o_query_mode && i_req.valid && i_req.offset == 8'h22)
        |=> (o_rsp.hit && o_rsp.data == 16'h0000))
        else $error("typical whole erase time-out not zero");
    AST_MAX_CHIP: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_clk_en && o_query_mode && i_req.valid && i_req.offset == 8'h26)
        |=> (o_rsp.hit && o_rsp.data == 16'h0000))
        else $error("max whole erase multiplier not zero");
    AST_MAX_WORD: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_clk_en && o_query_mode && i_req.valid && i_req.offset == 8'h23)
        |=> (o_rsp.hit && o_rsp.data == 16'h0001))
        else $error("max word program multiplier wrong");
    AST_SIZE: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_clk_en && o_query_mode && i_req.valid && i_req.offset == 8'h27)
        |=> (o_rsp.hit && o_rsp.data == {8'h00, CHK_SIZE}))
        else $error("device size exponent wrong");
    AST_IFACE: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_clk_en && o_query_mode && i_req.valid && i_req.offset == 8'h28)
        |=> (o_rsp.hit && o_rsp.data == 16'h0001))
        else $error("interface code low byte wrong");
    AST_WBUF: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_clk_en && o_query_mode && i_req.valid && i_req.offset == 8'h2a)
        |=> (o_rsp.hit && o_rsp.data == 16'h0006))
        else $error("write buffer size exponent wrong");
    AST_REGIONS: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_clk_en && o_query_mode && i_req.valid && i_req.offset == 8'h2c)
        |=> (o_rsp.hit && o_rsp.data == 16'h0001))
        else $error("erase region count wrong");
    AST_REGION_CNT: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_clk_en && o_query_mode && i_req.valid && i_req.offset == 8'h2d)
        |=> (o_rsp.hit && o_rsp.data == {8'h00, CHK_BLKS}))
        else $error("region block count wrong");
    AST_REGION_SIZE: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_clk_en && o_query_mode && i_req.valid && i_req.offset == 8'h30)
        |=> (o_rsp.hit && o_rsp.data == 16'h0002))
        else $error("region block size high byte wrong");
    AST_SIG_LAST: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_clk_en && o_query_mode && i_req.valid && i_req.offset == 8'h33)
        |=> (o_rsp.hit && o_rsp.data == 16'h0049))
        else $error("signature last byte wrong");
    AST_MAJOR: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_clk_en && o_query_mode && i_req.valid && i_req.offset == 8'h34)
        |=> (o_rsp.hit && o_rsp.data == 16'h0031))
        else $error("major version wrong");
    AST_FEAT_HI: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_clk_en && o_query_mode && i_req.valid && i_req.offset == 8'h37)
        |=> (o_rsp.hit && o_rsp.data == 16'h0001))
        else $error("feature second byte wrong");

    // unstored offsets, array mode, answer timing and freeze
    AST_UNSTORED: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_clk_en && o_query_mode && i_req.valid && (i_req.offset < 8'h15 ||
         (i_req.offset > 8'h16 && i_req.offset < 8'h1b) || i_req.offset > 8'h3a))
        |=> (!o_rsp.hit && o_rsp.data == 16'h0000))
        else $error("unstored location answered");
    AST_ARRAY_NOHIT: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_clk_en && !o_query_mode) |=> !o_rsp.hit)
        else $error("hit raised in array mode");
    AST_VALID_ECHO: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        i_clk_en |=> (o_rsp.valid == $past(i_req.valid)))
        else $error("answer valid not one cycle after request");
    AST_FREEZE: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        !i_clk_en |=> ($stable(o_rsp) && $stable(o_query_mode)))
        else $error("state moved with clock enable low");

    // covers
    COV_QUERY: cover property (@(posedge i_clk_sys) disable iff (i_reset) o_query_mode);
    COV_HIT: cover property (@(posedge i_clk_sys) disable iff (i_reset) o_rsp.hit);
    COV_BACK: cover property (@(posedge i_clk_sys) disable iff (i_reset)
        o_query_mode ##[1:20] !o_query_mode);
    COV_ARRAY_READ: cover property (@(posedge i_clk_sys) disable iff (i_reset)
        !o_query_mode && o_rsp.valid);
    COV_FREEZE: cover property (@(posedge i_clk_sys) disable iff (i_reset)
        !i_clk_en && o_query_mode);

endmodule : flash_query_info_rom

`default_nettype wire

// ---- verification/query_host_model.sv ----
// Purpose: host side model issuing commands and query reads
// Assumes: caller sits just after a rising edge when a task is entered
// Notes:   reads run back to back until idle is called
`timescale 1ns/1ps
`default_nettype none

module query_host_model
    import flash_query_info_rom_pkg::*;
(
    input  wire logic       i_clk_sys,
    input  wire query_rsp_t i_rsp,
    output var  logic       o_cmd_we,
    output var  logic [7:0] o_cmd_data,
    output var  query_req_t o_req
);
    // quiet bus at time zero
    initial begin
        o_cmd_we   = 1'b0;
        o_cmd_data = 8'h00;
        o_req      = '0;
    end

    // one command cycle, then one quiet edge so a next strobe is a fresh one
    task automatic command(input logic [7:0] code);
        o_cmd_we   = 1'b1;
        o_cmd_data = code;
        @(posedge i_clk_sys);
        #1;
        o_cmd_we   = 1'b0;
        o_cmd_data = ~code;
        @(posedge i_clk_sys);
        #1;
    endtask : command

    // one read, answer sampled just after the taking edge
    task automatic read(input logic [7:0] ofs, output query_rsp_t rsp);
        o_req = '{valid: 1'b1, offset: ofs};
        @(posedge i_clk_sys);
        #1;
        rsp = i_rsp;
    endtask : read

    // drop the request, offset lines inverted so nothing stale remains
    task automatic idle();
        o_req = '{valid: 1'b0, offset: ~o_req.offset};
        @(posedge i_clk_sys);
        #1;
    endtask : idle

    // multi-byte field, one location at a time, low byte first
    task automatic read_field(input logic [7:0] ofs, input int n, output logic [31:0] val);
        query_rsp_t r;
        val = '0;
        for (int i = 0; i < n; i++) begin
            read(ofs + 8'(i), r);
            val[8*i +: 8] = r.data[7:0];
        end
        idle();
    endtask : read_field
endmodule : query_host_model

`default_nettype wire

// ---- verification/flash_query_info_rom_test.sv ----
// Purpose: self-checking bench of the query information store
// Assumes: 128 Mbit density, commands 98h and FFh
// Notes:   expected bytes written out by hand per location
`timescale 1ns/1ps
`default_nettype none

module flash_query_info_rom_test;
    import flash_query_info_rom_pkg::*;
    logic        clk      = 1'b0;
    logic        rst      = 1'b1;
    logic        clk_en   = 1'b1;
    logic [15:0] arr_data = 16'h0000;
    logic        cmd_we;
    logic [7:0]  cmd_data;
    query_req_t  req;
    query_rsp_t  rsp;
    logic        qmode;
    int          failures    = 0;
    int          checks_done = 0;
    localparam logic [7:0] EXP_TAB [32] = '{8'h27, 8'h36, 8'h00, 8'h00, 8'h08, 8'h09, 8'h0a,
        8'h00, 8'h01, 8'h01, 8'h02, 8'h00, 8'h18, 8'h01, 8'h00, 8'h06, 8'h00, 8'h01, 8'h7f,
        8'h00, 8'h00, 8'h02, 8'h50, 8'h52, 8'h49, 8'h31, 8'h31, 8'he6, 8'h01, 8'h00, 8'h00, 8'h01};

    flash_query_info_rom #(.DENSITY(DENS_128M)) u_dut (.i_clk_sys(clk), .i_reset(rst),
        .i_clk_en(clk_en), .i_cmd_we(cmd_we), .i_cmd_data(cmd_data), .i_req(req),
        .i_array_data(arr_data), .o_rsp(rsp), .o_query_mode(qmode));
    query_host_model u_host (.i_clk_sys(clk), .i_rsp(rsp), .o_cmd_we(cmd_we),
        .o_cmd_data(cmd_data), .o_req(req));

    // 40 MHz clock
    always #12.5 clk = ~clk;

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : wrap_up

    // read in the cycle of the query command still sees array data
    task automatic test_array();
        query_rsp_t r;
        arr_data = 16'ha5c3;
        fork
            u_host.command(8'h98);
            u_host.read(8'h1b, r);
        join
        check("array read", {r.valid, r.hit, r.data}, {1'b1, 1'b0, 16'ha5c3});
        check("query mode", qmode, 1'b1);
        u_host.idle();
        $display("test_array done");
    endtask : test_array

    // table locations first..last read back to back, no idle at the end
    task automatic check_span(input int first, input int last);
        query_rsp_t r;
        for (int i = first; i <= last; i++) begin
            u_host.read(8'h1b + 8'(i), r);
            check("query byte", r, {2'b11, 8'h00, EXP_TAB[i]});
        end
    endtask : check_span

    // every stored location from 1Bh to 3Ah back to back, grouped by field
    task automatic test_table();
        check_span(0, 1);
        check_span(2, 3);
        check_span(4, 4);
        check_span(5, 5);
        check_span(6, 6);
        check_span(7, 7);
        check_span(8, 9);
        check_span(10, 10);
        check_span(11, 11);
        check_span(12, 12);
        check_span(13, 14);
        check_span(15, 16);
        check_span(17, 17);
        check_span(18, 21);
        check_span(22, 24);
        check_span(25, 26);
        check_span(27, 30);
        check_span(31, 31);
        u_host.idle();
        $display("test_table done");
    endtask : test_table

    // multi-byte fields, extended table found through the pointer
    task automatic test_fields();
        logic [31:0] v;
        u_host.read_field(8'h15, 2, v);
        check("table pointer", v, 32'h0000_0031);
        u_host.read_field(v[7:0], 3, v);
        check("signature", v, 32'h0049_5250);
        u_host.read_field(8'h2d, 4, v);
        check("region descriptor", v, 32'h0200_007f);
        u_host.read_field(8'h36, 4, v);
        check("feature bitmap", v, 32'h0000_01e6);
        u_host.read_field(8'h28, 2, v);
        check("interface code", v, 32'h0000_0001);
        u_host.read_field(8'h2a, 2, v);
        check("buffer size", v, 32'h0000_0006);
        $display("test_fields done");
    endtask : test_fields

    // locations just outside the store, unknown and return commands
    task automatic test_refused();
        query_rsp_t r;
        u_host.read(8'h1a, r);
        check("below store", {r.valid, r.hit, r.data}, 18'h2_0000);
        u_host.read(8'h3b, r);
        check("above store", {r.valid, r.hit, r.data}, 18'h2_0000);
        u_host.idle();
        u_host.command(8'h50);
        check("unknown command", qmode, 1'b1);
        u_host.command(8'hff);
        check("array return", qmode, 1'b0);
        $display("test_refused done");
    endtask : test_refused

    // clock enable low freezes mode and answer
    task automatic test_freeze();
        query_rsp_t r;
        query_rsp_t held;
        u_host.command(8'h98);
        u_host.read(8'h1b, r);
        held   = rsp;
        clk_en = 1'b0;
        u_host.read(8'h25, r);
        check("frozen answer", r, held);
        u_host.idle();
        u_host.command(8'hff);
        check("frozen mode", qmode, 1'b1);
        clk_en = 1'b1;
        u_host.read(8'h25, r);
        check("thawed read", r.data, 16'h0002);
        u_host.idle();
        $display("test_freeze done");
    endtask : test_freeze

    // reset in mid-run drops back to array mode and clears the answer
    task automatic test_reset();
        query_rsp_t r;
        rst = 1'b1;
        @(posedge clk);
        #1;
        check("mid reset mode", qmode, 1'b0);
        check("mid reset answer", rsp, 18'h0_0000);
        rst = 1'b0;
        u_host.read(8'h1b, r);
        check("array after reset", r, {2'b10, 16'ha5c3});
        u_host.idle();
        $display("test_reset done");
    endtask : test_reset

    // reset, then the scenarios
    initial begin
        repeat (20) @(posedge clk);
        #1;
        check("reset mode", qmode, 1'b0);
        check("reset answer", rsp, 18'h0_0000);
        rst = 1'b0;
        @(posedge clk);
        #1;
        test_array();
        test_table();
        test_fields();
        test_refused();
        test_freeze();
        test_reset();
        wrap_up();
    end

    // watchdog well beyond the expected run
    initial begin
        #(25 * 4000);
        failures++;
        wrap_up();
    end
endmodule : flash_query_info_rom_test

`default_nettype wire
